// ### include/dwuc_pkg.sv
// Purpose: Shared constants and types of the debug watchdog unlock control.
// Assumes: One 50 MHz clock; battery power-on reset is the only reset.
// Notes: Times are kept in microseconds; cycle counts derive from the clock rate.
package dwuc_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

  // Normal-request timeout once the watchdog is armed
  localparam int unsigned NR_TIMEOUT_US = 75_000;
  localparam int unsigned NR_TIMEOUT_CYC = NR_TIMEOUT_US * CYC_PER_US;

  // Length of the reset pulse after a watchdog bite; plain default
  localparam int unsigned RST_HOLD_US = 1_000;
  localparam int unsigned RST_HOLD_CYC = RST_HOLD_US * CYC_PER_US;

  // Selectable watchdog periods; plain defaults
  localparam int unsigned WD_PERIOD0_US = 10_000;
  localparam int unsigned WD_PERIOD1_US = 50_000;
  localparam int unsigned WD_PERIOD2_US = 100_000;
  localparam int unsigned WD_PERIOD3_US = 200_000;
  localparam int unsigned WD_PERIOD0_CYC = WD_PERIOD0_US * CYC_PER_US;
  localparam int unsigned WD_PERIOD1_CYC = WD_PERIOD1_US * CYC_PER_US;
  localparam int unsigned WD_PERIOD2_CYC = WD_PERIOD2_US * CYC_PER_US;
  localparam int unsigned WD_PERIOD3_CYC = WD_PERIOD3_US * CYC_PER_US;

  localparam int unsigned CNT_W = 32;
  localparam int unsigned WD_SEL_W = 2;

  localparam logic BATT_FAIL_RST = 1'b1;
  localparam logic ARMED_RST = 1'b0;
  localparam logic [WD_SEL_W-1:0] WD_SEL_RST = 2'h0;

  typedef enum logic [1:0] {
    DWUC_NORMAL_REQ,
    DWUC_NORMAL,
    DWUC_SLEEP,
    DWUC_RESET
  } dwuc_mode_t;

endpackage

// ### src/dwuc_debug_watchdog_unlock_control.sv
// Purpose: Mode and watchdog arming control of the debug variant of the basis chip.
// Assumes: SPI decoding is done outside; its events arrive as one-cycle pulses.
// Notes: The watchdog is disarmed after every battery power-on until software
//   reads the supply status register; arming can never be undone by software.
module dwuc_debug_watchdog_unlock_control
  import dwuc_pkg::*;
#(
  parameter int unsigned NR_TIMEOUT_CYC_P = NR_TIMEOUT_CYC,
  parameter int unsigned RST_HOLD_CYC_P = RST_HOLD_CYC,
  parameter int unsigned WD_PERIOD0_CYC_P = WD_PERIOD0_CYC,
  parameter int unsigned WD_PERIOD1_CYC_P = WD_PERIOD1_CYC,
  parameter int unsigned WD_PERIOD2_CYC_P = WD_PERIOD2_CYC,
  parameter int unsigned WD_PERIOD3_CYC_P = WD_PERIOD3_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic wdog_ctrl_wr_i,
  input wire logic [WD_SEL_W-1:0] wdog_period_sel_i,
  input wire logic status_rd_i,
  input wire logic sleep_cmd_i,
  input wire logic wake_i,
  output logic [1:0] mode_o,
  output logic main_regulator_on_o,
  output logic can_supply_regulator_on_o,
  output logic battery_switch_output_on_o,
  output logic can_term_vbat_o,
  output logic wdog_reset_o,
  output logic wdog_armed_o,
  output logic battery_fail_flag_o,
  output logic [WD_SEL_W-1:0] wdog_period_sel_o
);

  dwuc_mode_t mode;
  dwuc_mode_t next_mode;
  logic [CNT_W-1:0] tmr;
  logic armed;
  logic battery_fail_flag;
  logic [WD_SEL_W-1:0] wd_sel;
  logic tmr_expire;
  logic wd_expire;
  logic nr_expire;
  logic hold_expire;

  function automatic logic [CNT_W-1:0] wd_limit(input logic [WD_SEL_W-1:0] sel);
    logic [CNT_W-1:0] lim;
    lim = CNT_W'(WD_PERIOD0_CYC_P);
    case (sel)
      2'h0: lim = CNT_W'(WD_PERIOD0_CYC_P);
      2'h1: lim = CNT_W'(WD_PERIOD1_CYC_P);
      2'h2: lim = CNT_W'(WD_PERIOD2_CYC_P);
      default: lim = CNT_W'(WD_PERIOD3_CYC_P);
    endcase
    return lim;
  endfunction

  function automatic logic reached(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] lim);
    // Greater-or-equal so a count carried over into arming bites at once
    return (cnt >= lim - CNT_W'(1));
  endfunction

  always_comb begin
    wd_expire = (mode == DWUC_NORMAL) && reached(tmr, wd_limit(wd_sel));
    nr_expire = (mode == DWUC_NORMAL_REQ) && reached(tmr, CNT_W'(NR_TIMEOUT_CYC_P));
    hold_expire = (mode == DWUC_RESET) && reached(tmr, CNT_W'(RST_HOLD_CYC_P));
    tmr_expire = wd_expire || nr_expire || hold_expire;
  end

  // Sticky arm flag; no software path clears it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      armed <= ARMED_RST;
    end else if (status_rd_i) begin
      armed <= 1'b1;
    end
  end

  // Set only by battery power-on, so no set/clear race exists
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      battery_fail_flag <= BATT_FAIL_RST;
    end else if (status_rd_i) begin
      battery_fail_flag <= 1'b0;
    end
  end

  // Period is taken from each trigger word in normal request or normal mode
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wd_sel <= WD_SEL_RST;
    end else if (wdog_ctrl_wr_i && (mode == DWUC_NORMAL_REQ || mode == DWUC_NORMAL)) begin
      wd_sel <= wdog_period_sel_i;
    end
  end

  always_comb begin
    next_mode = mode;
    case (mode)
      DWUC_NORMAL_REQ: begin
        if (wdog_ctrl_wr_i) begin
          next_mode = DWUC_NORMAL;
        end else if (nr_expire && armed) begin
          next_mode = DWUC_SLEEP;
        end
      end
      DWUC_NORMAL: begin
        // A bite outranks a sleep command issued in the same cycle
        if (wd_expire && armed) begin
          next_mode = DWUC_RESET;
        end else if (sleep_cmd_i) begin
          next_mode = DWUC_SLEEP;
        end
      end
      DWUC_SLEEP: begin
        if (wake_i) begin
          next_mode = DWUC_NORMAL_REQ;
        end
      end
      DWUC_RESET: begin
        if (hold_expire) begin
          next_mode = DWUC_NORMAL_REQ;
        end
      end
      default: next_mode = DWUC_NORMAL_REQ;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode <= DWUC_NORMAL_REQ;
    end else begin
      mode <= next_mode;
    end
  end

  // One timer serves the normal-request timeout, the watchdog and the reset hold
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tmr <= '0;
    end else if (next_mode != mode) begin
      tmr <= '0;
    end else if (mode == DWUC_NORMAL && wdog_ctrl_wr_i) begin
      tmr <= '0;
    end else if (tmr_expire) begin
      // Unarmed expiry just restarts the count; no reset, no sleep
      tmr <= '0;
    end else if (mode != DWUC_SLEEP) begin
      tmr <= tmr + CNT_W'(1);
    end
  end

  always_comb begin
    mode_o = mode;
    main_regulator_on_o = (mode != DWUC_SLEEP);
    can_supply_regulator_on_o = (mode == DWUC_NORMAL);
    battery_switch_output_on_o = 1'b0;
    can_term_vbat_o = (mode != DWUC_NORMAL);
    wdog_reset_o = (mode == DWUC_RESET);
    wdog_armed_o = armed;
    battery_fail_flag_o = battery_fail_flag;
    wdog_period_sel_o = wd_sel;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_nr_trigger;
    mode == DWUC_NORMAL_REQ && wdog_ctrl_wr_i;
  endsequence

  sequence s_in_normal_powered;
    mode == DWUC_NORMAL && main_regulator_on_o && can_supply_regulator_on_o;
  endsequence

  sequence s_bite;
    mode == DWUC_NORMAL && armed && wd_expire;
  endsequence

  sequence s_reset_entered;
    wdog_reset_o && tmr == '0;
  endsequence

  property p_nr_outputs;
    mode == DWUC_NORMAL_REQ |-> main_regulator_on_o && !can_supply_regulator_on_o
      && !battery_switch_output_on_o && can_term_vbat_o;
  endproperty
  a_nr_outputs: assert property (p_nr_outputs) else $error("bad outputs in normal request");

  property p_nr_hold_unarmed;
    !armed && mode == DWUC_NORMAL_REQ && !wdog_ctrl_wr_i |=> mode == DWUC_NORMAL_REQ;
  endproperty
  a_nr_hold_unarmed: assert property (p_nr_hold_unarmed) else $error("left normal request");

  property p_nr_exit;
    s_nr_trigger |=> s_in_normal_powered;
  endproperty
  a_nr_exit: assert property (p_nr_exit) else $error("trigger did not enter normal");

  property p_sleep_cmd;
    // Supplies are checked on entry only, since a wake may follow at once
    mode == DWUC_NORMAL && sleep_cmd_i && !(armed && wd_expire) |=> mode == DWUC_SLEEP
      && !main_regulator_on_o && !can_supply_regulator_on_o;
  endproperty
  a_sleep_cmd: assert property (p_sleep_cmd) else $error("sleep command ignored");

  property p_wake;
    mode == DWUC_SLEEP && wake_i |=> mode == DWUC_NORMAL_REQ && tmr == '0;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not enter normal request");

  property p_unarmed_no_reset;
    !armed |-> !wdog_reset_o;
  endproperty
  a_unarmed_no_reset: assert property (p_unarmed_no_reset) else $error("reset while unarmed");

  property p_arm;
    status_rd_i |=> armed && !battery_fail_flag_o && wdog_armed_o;
  endproperty
  a_arm: assert property (p_arm) else $error("status read did not arm");

  property p_nr_timeout;
    armed && nr_expire && !wdog_ctrl_wr_i |=> mode == DWUC_SLEEP;
  endproperty
  a_nr_timeout: assert property (p_nr_timeout) else $error("armed timeout did not sleep");

  property p_bite;
    s_bite |=> s_reset_entered;
  endproperty
  a_bite: assert property (p_bite) else $error("armed expiry gave no reset");

  property p_reset_return;
    hold_expire |=> mode == DWUC_NORMAL_REQ && !wdog_reset_o;
  endproperty
  a_reset_return: assert property (p_reset_return) else $error("reset did not return");

  property p_armed_sticky;
    armed |=> armed [*2];
  endproperty
  a_armed_sticky: assert property (p_armed_sticky) else $error("watchdog disarmed");

  property p_flag_only_cleared;
    !battery_fail_flag_o |=> !battery_fail_flag_o;
  endproperty
  a_flag_only_cleared: assert property (p_flag_only_cleared) else $error("flag set again");

  property p_period_taken;
    s_nr_trigger |=> wdog_period_sel_o == $past(wdog_period_sel_i);
  endproperty
  a_period_taken: assert property (p_period_taken) else $error("period not taken");

  property p_flag_gates;
    !armed && mode == DWUC_NORMAL && wd_expire && !sleep_cmd_i |=> mode == DWUC_NORMAL
      && tmr == '0;
  endproperty
  a_flag_gates: assert property (p_flag_gates) else $error("unarmed expiry acted");

endmodule // dwuc_debug_watchdog_unlock_control

// ### verification/dwuc_host_model.sv
// Purpose: Host microcontroller model that issues decoded SPI events to the block.
// Assumes: Each event is a one-cycle pulse launched just after a rising edge.
// Notes: Between events the select lines show the inverse of the last value.
module dwuc_host_model
  import dwuc_pkg::*;
(
  input wire logic clk_i,
  output logic wr_o,
  output logic [WD_SEL_W-1:0] sel_o,
  output logic rd_o,
  output logic sleep_o,
  output logic wake_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    wr_o = 1'b0;
    sel_o = 2'h0;
    rd_o = 1'b0;
    sleep_o = 1'b0;
    wake_o = 1'b0;
  end

  // Op 1 trigger write, 2 status read, 3 sleep command, 4 wake event
  task automatic send(input int op, input logic [WD_SEL_W-1:0] sel);
    @(posedge clk_i);
    wr_o <= (op == 1);
    sel_o <= sel;
    rd_o <= (op == 2);
    sleep_o <= (op == 3);
    wake_o <= (op == 4);
    @(posedge clk_i);
    wr_o <= 1'b0;
    sel_o <= ~sel;
    rd_o <= 1'b0;
    sleep_o <= 1'b0;
    wake_o <= 1'b0;
  endtask
endmodule // dwuc_host_model

// ### verification/test_debug_watchdog_unlock_control.sv
// Purpose: Self-checking bench of the debug watchdog unlock control.
// Assumes: Shortened counts: timeout 50, reset hold 5, periods 20/40/60/80 cycles.
// Notes: Rows cover the unarmed flow; arming, bite, timeout and reset are hand-written.
module test_debug_watchdog_unlock_control
  import dwuc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NR = 50;
  localparam int HOLD = 5;
  typedef struct {int op; int sel; int cyc; int mode; int per;} dwuc_row_t;
  dwuc_row_t rows[12] = '{'{0, 0, 60, 0, 0}, '{1, 3, 0, 1, 3}, '{0, 0, 100, 1, 3},
    '{3, 0, 0, 2, 3}, '{4, 0, 0, 0, 3}, '{1, 1, 0, 1, 1}, '{1, 2, 0, 1, 2}, '{3, 0, 0, 2, 2},
    '{4, 0, 0, 0, 2}, '{0, 0, 60, 0, 2}, '{3, 0, 0, 0, 2}, '{4, 0, 0, 0, 2}};
  logic clk, rstn, wr, rd, slp, wake, main, can, sw, term, wrst, armed, flag;
  logic [1:0] sel, mode, psel;
  int miscompares = 0;
  int n_compared = 0;
  int n;

  dwuc_host_model host_u (.clk_i(clk), .wr_o(wr), .sel_o(sel), .rd_o(rd), .sleep_o(slp),
    .wake_o(wake));
  dwuc_debug_watchdog_unlock_control #(.NR_TIMEOUT_CYC_P(NR), .RST_HOLD_CYC_P(HOLD),
    .WD_PERIOD0_CYC_P(20), .WD_PERIOD1_CYC_P(40), .WD_PERIOD2_CYC_P(60),
    .WD_PERIOD3_CYC_P(80)) dut_u (.clk_i(clk), .rstn_i(rstn), .wdog_ctrl_wr_i(wr),
    .wdog_period_sel_i(sel), .status_rd_i(rd), .sleep_cmd_i(slp), .wake_i(wake),
    .mode_o(mode), .main_regulator_on_o(main), .can_supply_regulator_on_o(can),
    .battery_switch_output_on_o(sw), .can_term_vbat_o(term), .wdog_reset_o(wrst),
    .wdog_armed_o(armed), .battery_fail_flag_o(flag), .wdog_period_sel_o(psel));

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [1:0] exp, input logic [1:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic check_mode(input logic [1:0] m);
    check("mode", m, mode);
    check("main_on", m != 2'h2, main);
    check("can_on", m == 2'h1, can);
    check("switch_on", 2'h0, sw);
    check("term", m != 2'h1, term);
    check("wdog_reset", m == 2'h3, wrst);
  endtask

  // Bounded wait; running out ends the run as a failure
  task automatic wait_mode(input logic [1:0] m, input int lim, output int cnt);
    cnt = 0;
    while (mode !== m && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
    if (mode !== m) begin
      $display("CHECK FAILED mode_wait expected %0h seen %0h", m, mode);
      miscompares++;
      give_verdict();
    end
  endtask

  // An unarmed watchdog must never pull reset
  always @(negedge clk) begin
    if (rstn === 1'b1 && armed === 1'b0 && wrst !== 1'b0) begin
      $display("CHECK FAILED unarmed_reset expected 0 seen %0h", wrst);
      miscompares++;
    end
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    rstn = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check_mode(2'h0);
    check("flag", 2'h1, flag);
    foreach (rows[i]) begin
      if (rows[i].op == 0) repeat (rows[i].cyc) @(posedge clk);
      else host_u.send(rows[i].op, rows[i].sel[1:0]);
      @(negedge clk);
      check_mode(rows[i].mode[1:0]);
      check("period", rows[i].per[1:0], psel);
      check("armed", 2'h0, armed);
      $display("row %0d done", i);
    end
    host_u.send(1, 2'h0);
    host_u.send(2, 2'h0);
    @(negedge clk);
    check("armed", 2'h1, armed);
    check("flag", 2'h0, flag);
    wait_mode(2'h3, 40, n);
    check_mode(2'h3);
    wait_mode(2'h0, HOLD + 3, n);
    check("hold", 2'h1, n == HOLD);
    wait_mode(2'h2, NR + 5, n);
    check("nr_timeout", 2'h1, n == NR);
    check_mode(2'h2);
    $display("arm and timeout test done");
    host_u.send(4, 2'h0);
    host_u.send(2, 2'h0);
    host_u.send(1, 2'h0);
    // Refresh every 17 cycles keeps the armed 20-cycle watchdog quiet
    repeat (3) begin
      repeat (15) @(posedge clk);
      host_u.send(1, 2'h0);
    end
    @(negedge clk);
    check_mode(2'h1);
    host_u.send(3, 2'h0);
    @(negedge clk);
    check("armed", 2'h1, armed);
    $display("no disarm test done");
    @(posedge clk);
    rstn <= 1'b0;
    @(negedge clk);
    check("armed", 2'h0, armed);
    check("flag", 2'h1, flag);
    check_mode(2'h0);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (NR + 10) @(posedge clk);
    @(negedge clk);
    check_mode(2'h0);
    $display("power-on reset test done");
    give_verdict();
  end
endmodule // test_debug_watchdog_unlock_control
